// ===== src/vgpd_pkg.sv
// Constants and types for the graphics plane datapath
`default_nettype none

package vgpd_pkg;

  // ==========================================================================
  // Host register ports and indices
  localparam logic [15:0] VGPD_INDEX_PORT = 16'h03CE;
  localparam logic [15:0] VGPD_DATA_PORT = 16'h03CF;
  localparam logic [3:0] IDX_FILL_VALUE = 4'h0;
  localparam logic [3:0] IDX_FILL_ENABLE = 4'h1;
  localparam logic [3:0] IDX_COMPARE_COLOR = 4'h2;
  localparam logic [3:0] IDX_ROTATE_LOGIC = 4'h3;
  localparam logic [3:0] IDX_READ_PLANE = 4'h4;
  localparam logic [3:0] IDX_MODE_CONTROL = 4'h5;
  localparam logic [3:0] IDX_WINDOW_CONTROL = 4'h6;
  localparam logic [3:0] IDX_COMPARE_ENABLE = 4'h7;
  localparam logic [3:0] IDX_PIXEL_MASK = 4'h8;

  // ==========================================================================
  // Field positions
  localparam int ROT_CNT_LSB = 0;
  localparam int ROT_FUNC_LSB = 3;
  localparam int MODE_WM_LSB = 0;
  localparam int MODE_RM_BIT = 3;
  localparam int MODE_OE_BIT = 4;
  localparam int MODE_SR_BIT = 5;
  localparam int MODE_PAL_BIT = 6;
  localparam int MISC_GM_BIT = 0;
  localparam int MISC_COE_BIT = 1;
  localparam int MISC_MAP_LSB = 2;
  localparam int CHAIN_SUB_LO = 14;
  localparam int CHAIN_SUB_HI = 16;

  // ==========================================================================
  // Widths and reset values
  localparam int HOST_AW = 20;
  localparam int BUF_AW = 17;
  localparam logic [3:0] NIBBLE_ZERO = 4'h0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONES = 8'hFF;
  localparam logic [3:0] PAIR_EVEN = 4'h5;
  localparam logic [3:0] PAIR_ODD = 4'hA;

  // ==========================================================================
  // Host memory windows
  localparam logic [HOST_AW-1:0] WIN_BASE_A0 = 20'hA0000;
  localparam logic [HOST_AW-1:0] WIN_BASE_B0 = 20'hB0000;
  localparam logic [HOST_AW-1:0] WIN_BASE_B8 = 20'hB8000;
  localparam logic [HOST_AW-1:0] WIN_MASK_128K = 20'hE0000;
  localparam logic [HOST_AW-1:0] WIN_MASK_64K = 20'hF0000;
  localparam logic [HOST_AW-1:0] WIN_MASK_32K = 20'hF8000;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    WMODE_ALU = 2'b00,
    WMODE_LATCH = 2'b01,
    WMODE_SPREAD = 2'b10,
    WMODE_FILL = 2'b11
  } vgpd_wmode_t;

  typedef enum logic [1:0] {
    FUNC_PASS = 2'b00,
    FUNC_AND = 2'b01,
    FUNC_OR = 2'b10,
    FUNC_XOR = 2'b11
  } vgpd_func_t;

  typedef enum logic [1:0] {
    MAP_128K_A0 = 2'b00,
    MAP_64K_A0 = 2'b01,
    MAP_32K_B0 = 2'b10,
    MAP_32K_B8 = 2'b11
  } vgpd_map_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RD_WAIT = 2'b01,
    ST_RD_DONE = 2'b11
  } vgpd_state_t;

  typedef logic [3:0][7:0] vgpd_planes_t;

  typedef struct packed {
    logic full_palette_shift;
    logic legacy_shift_packing;
    logic odd_even_mode;
    logic chain_pairs;
    logic graphics_display_select;
  } vgpd_video_cfg_t;

endpackage : vgpd_pkg

`default_nettype wire

// ===== src/vgpd_plane_alu.sv
// Per-plane write path: source select, logic function and pixel mask
`default_nettype none

module vgpd_plane_alu
  import vgpd_pkg::*;
(
  input wire vgpd_wmode_t mode,
  input wire vgpd_func_t func,
  input wire logic fill_bit,
  input wire logic fill_en,
  input wire logic host_bit,
  input wire logic [7:0] rotated,
  input wire logic [7:0] latch,
  input wire logic [7:0] pixel_mask,
  output logic [7:0] result
);

  logic [7:0] src;
  logic [7:0] combined;
  logic [7:0] mask;

  always_comb begin
    src = rotated;
    mask = pixel_mask;
    unique case (mode)
      WMODE_ALU: src = fill_en ? {8{fill_bit}} : rotated;
      WMODE_LATCH: mask = BYTE_ZERO;
      WMODE_SPREAD: src = {8{host_bit}};
      WMODE_FILL: begin
        src = {8{fill_bit}};
        mask = rotated & pixel_mask;
      end
    endcase
  end

  always_comb begin
    unique case (func)
      FUNC_PASS: combined = src;
      FUNC_AND: combined = src & latch;
      FUNC_OR: combined = src | latch;
      FUNC_XOR: combined = src ^ latch;
    endcase
  end

  // Cleared mask bits keep the latched pixel
  assign result = (combined & mask) | (latch & ~mask);

endmodule : vgpd_plane_alu

`default_nettype wire

// ===== src/vgpd_graphics_core.sv
// Graphics controller plane datapath with indexed host registers
// ============================================================================
// Behaviour
// - Data port accesses register chosen by index
// - Fill bits feed planes in modes 0, 3
// - Mode 0 enable picks fill or host data
// - Read mode 1 returns eight-pixel colour match
// - Compare enable bits include planes in compare
// - Function: pass, AND, OR, XOR with latches
// - Host data rotated right before fill substitution
// - Read mode 0 returns selected plane byte
// - Mode bit 6 selects 256-colour shift arrangement
// - Mode bit 5 selects CGA shift packing
// - Mode bit 4 selects even/odd addressing
// - Mode bit 3 selects plane or compare read
// - Mode 0: source, function, then pixel mask
// - Mode 1 writes latches unchanged
// - Mode 2 masks host data into planes
// - Mode 3 fills all; mask is rotated data AND pixel mask
// - Memory map field decodes one host window
// - Chaining: A0 picks pair, A14/A16 substitutes
// - Misc bit 0 selects text or graphics
// - Mask bit set lets pixel change
// - Index port selects registers 0 to 8
`default_nettype none

module vgpd_graphics_core
  import vgpd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  input wire logic [HOST_AW-1:0] mem_addr,
  input wire logic mem_wr,
  input wire logic mem_rd,
  input wire logic [7:0] mem_wdata,
  output logic mem_ready,
  output logic mem_hit,
  output logic [7:0] mem_rdata,
  output logic mem_rvalid,
  input wire logic [3:0] sequencer_plane_mask,
  output logic [BUF_AW-1:0] plane_addr,
  output logic plane_rd,
  output logic [3:0] plane_we,
  output vgpd_planes_t plane_wdata,
  input wire vgpd_planes_t plane_rdata,
  output vgpd_video_cfg_t video_cfg
);

  // ==========================================================================
  // Helper functions
  function automatic logic [7:0] rotate_right(input logic [7:0] d, input logic [2:0] n);
    logic [15:0] twice;
    twice = {d, d} >> n;
    return twice[7:0];
  endfunction : rotate_right

  function automatic logic [HOST_AW-1:0] window_base(input vgpd_map_t m);
    logic [HOST_AW-1:0] b;
    unique case (m)
      MAP_128K_A0: b = WIN_BASE_A0;
      MAP_64K_A0: b = WIN_BASE_A0;
      MAP_32K_B0: b = WIN_BASE_B0;
      MAP_32K_B8: b = WIN_BASE_B8;
    endcase
    return b;
  endfunction : window_base

  function automatic logic [HOST_AW-1:0] window_mask(input vgpd_map_t m);
    logic [HOST_AW-1:0] k;
    unique case (m)
      MAP_128K_A0: k = WIN_MASK_128K;
      MAP_64K_A0: k = WIN_MASK_64K;
      MAP_32K_B0: k = WIN_MASK_32K;
      MAP_32K_B8: k = WIN_MASK_32K;
    endcase
    return k;
  endfunction : window_mask

  // ==========================================================================
  // Register storage
  logic [3:0] plane_logic_index_port;
  logic [3:0] plane_fill_value;
  logic [3:0] plane_fill_enable;
  logic [3:0] compare_color_value;
  logic [2:0] rotate_count;
  vgpd_func_t logic_func;
  logic [1:0] plane_to_read;
  logic full_palette_shift;
  logic legacy_shift_packing;
  logic odd_even_mode;
  logic read_path_select;
  vgpd_wmode_t write_path_select;
  vgpd_map_t memory_map;
  logic chain_pairs;
  logic graphics_display_select;
  logic [3:0] compare_plane_enable;
  logic [7:0] pixel_write_mask;

  logic index_wr;
  logic data_wr;
  logic data_rd;
  logic index_rd;

  assign index_wr = io_wr && (io_addr == VGPD_INDEX_PORT);
  assign data_wr = io_wr && (io_addr == VGPD_DATA_PORT);
  assign index_rd = io_rd && (io_addr == VGPD_INDEX_PORT);
  assign data_rd = io_rd && (io_addr == VGPD_DATA_PORT);

  // ==========================================================================
  // Index register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      plane_logic_index_port <= NIBBLE_ZERO;
    end else if (index_wr) begin
      plane_logic_index_port <= io_wdata[3:0];
    end
  end

  // ==========================================================================
  // Indexed register writes
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      plane_fill_value <= NIBBLE_ZERO;
      plane_fill_enable <= NIBBLE_ZERO;
      compare_color_value <= NIBBLE_ZERO;
      compare_plane_enable <= NIBBLE_ZERO;
    end else if (data_wr) begin
      unique case (plane_logic_index_port)
        IDX_FILL_VALUE: plane_fill_value <= io_wdata[3:0];
        IDX_FILL_ENABLE: plane_fill_enable <= io_wdata[3:0];
        IDX_COMPARE_COLOR: compare_color_value <= io_wdata[3:0];
        IDX_COMPARE_ENABLE: compare_plane_enable <= io_wdata[3:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rotate_count <= 3'h0;
      logic_func <= FUNC_PASS;
      plane_to_read <= 2'h0;
      pixel_write_mask <= BYTE_ZERO;
    end else if (data_wr) begin
      unique case (plane_logic_index_port)
        IDX_ROTATE_LOGIC: begin
          rotate_count <= io_wdata[ROT_CNT_LSB +: 3];
          logic_func <= vgpd_func_t'(io_wdata[ROT_FUNC_LSB +: 2]);
        end
        IDX_READ_PLANE: plane_to_read <= io_wdata[1:0];
        IDX_PIXEL_MASK: pixel_write_mask <= io_wdata;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      full_palette_shift <= 1'b0;
      legacy_shift_packing <= 1'b0;
      odd_even_mode <= 1'b0;
      read_path_select <= 1'b0;
      write_path_select <= WMODE_ALU;
    end else if (data_wr && (plane_logic_index_port == IDX_MODE_CONTROL)) begin
      full_palette_shift <= io_wdata[MODE_PAL_BIT];
      legacy_shift_packing <= io_wdata[MODE_SR_BIT];
      odd_even_mode <= io_wdata[MODE_OE_BIT];
      read_path_select <= io_wdata[MODE_RM_BIT];
      write_path_select <= vgpd_wmode_t'(io_wdata[MODE_WM_LSB +: 2]);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      memory_map <= MAP_128K_A0;
      chain_pairs <= 1'b0;
      graphics_display_select <= 1'b0;
    end else if (data_wr && (plane_logic_index_port == IDX_WINDOW_CONTROL)) begin
      memory_map <= vgpd_map_t'(io_wdata[MISC_MAP_LSB +: 2]);
      chain_pairs <= io_wdata[MISC_COE_BIT];
      graphics_display_select <= io_wdata[MISC_GM_BIT];
    end
  end

  // ==========================================================================
  // Register read-back, reserved bits as zero
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      io_rdata <= BYTE_ZERO;
    end else if (index_rd) begin
      io_rdata <= {NIBBLE_ZERO, plane_logic_index_port};
    end else if (data_rd) begin
      io_rdata <= BYTE_ZERO;
      unique case (plane_logic_index_port)
        IDX_FILL_VALUE: io_rdata[3:0] <= plane_fill_value;
        IDX_FILL_ENABLE: io_rdata[3:0] <= plane_fill_enable;
        IDX_COMPARE_COLOR: io_rdata[3:0] <= compare_color_value;
        IDX_ROTATE_LOGIC: begin
          io_rdata[ROT_CNT_LSB +: 3] <= rotate_count;
          io_rdata[ROT_FUNC_LSB +: 2] <= logic_func;
        end
        IDX_READ_PLANE: io_rdata[1:0] <= plane_to_read;
        IDX_MODE_CONTROL: begin
          io_rdata[MODE_PAL_BIT] <= full_palette_shift;
          io_rdata[MODE_SR_BIT] <= legacy_shift_packing;
          io_rdata[MODE_OE_BIT] <= odd_even_mode;
          io_rdata[MODE_RM_BIT] <= read_path_select;
          io_rdata[MODE_WM_LSB +: 2] <= write_path_select;
        end
        IDX_WINDOW_CONTROL: begin
          io_rdata[MISC_MAP_LSB +: 2] <= memory_map;
          io_rdata[MISC_COE_BIT] <= chain_pairs;
          io_rdata[MISC_GM_BIT] <= graphics_display_select;
        end
        IDX_COMPARE_ENABLE: io_rdata[3:0] <= compare_plane_enable;
        IDX_PIXEL_MASK: io_rdata <= pixel_write_mask;
        default: begin
        end
      endcase
    end
  end

  // ==========================================================================
  // Video shifter configuration
  always_comb begin
    video_cfg.full_palette_shift = full_palette_shift;
    video_cfg.legacy_shift_packing = legacy_shift_packing;
    video_cfg.odd_even_mode = odd_even_mode;
    video_cfg.chain_pairs = chain_pairs;
    video_cfg.graphics_display_select = graphics_display_select;
  end

  // ==========================================================================
  // Host window decode and address chaining
  logic [HOST_AW-1:0] win_offset;
  logic [BUF_AW-1:0] next_buf_addr;
  logic [3:0] pair_planes;

  assign mem_hit = (mem_addr & window_mask(memory_map)) == window_base(memory_map);
  assign win_offset = mem_addr & ~window_mask(memory_map);

  always_comb begin
    next_buf_addr = win_offset[BUF_AW-1:0];
    pair_planes = BYTE_ONES[3:0];
    if (chain_pairs) begin
      pair_planes = mem_addr[0] ? PAIR_ODD : PAIR_EVEN;
      if ((memory_map == MAP_128K_A0) || (memory_map == MAP_32K_B0)) begin
        next_buf_addr[0] = mem_addr[CHAIN_SUB_LO];
      end else begin
        next_buf_addr[0] = mem_addr[CHAIN_SUB_HI];
      end
    end else if (odd_even_mode) begin
      pair_planes = mem_addr[0] ? PAIR_ODD : PAIR_EVEN;
    end
  end

  // ==========================================================================
  // Access sequencer
  vgpd_state_t state;
  vgpd_state_t next_state;
  logic rd_take;
  logic wr_take;
  logic rd_odd;

  assign mem_ready = (state == ST_IDLE);
  assign rd_take = mem_ready && mem_rd && mem_hit;
  assign wr_take = mem_ready && mem_wr && !mem_rd && mem_hit;

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: if (rd_take) next_state = ST_RD_WAIT;
      ST_RD_WAIT: next_state = ST_RD_DONE;
      ST_RD_DONE: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      plane_addr <= {BUF_AW{1'b0}};
      plane_rd <= 1'b0;
      rd_odd <= 1'b0;
    end else begin
      plane_rd <= rd_take;
      if (rd_take || wr_take) begin
        plane_addr <= next_buf_addr;
        rd_odd <= mem_addr[0];
      end
    end
  end

  // ==========================================================================
  // Processor latches and read result
  vgpd_planes_t proc_latch;
  logic [7:0] compare_result;
  logic [1:0] read_plane;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      proc_latch <= '0;
    end else if (state == ST_RD_WAIT) begin
      proc_latch <= plane_rdata;
    end
  end

  // A pixel matches when every enabled plane agrees with its colour bit
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      compare_result[b] = 1'b1;
      for (int p = 0; p < 4; p++) begin
        if (compare_plane_enable[p] && (plane_rdata[p][b] != compare_color_value[p])) begin
          compare_result[b] = 1'b0;
        end
      end
    end
  end

  always_comb begin
    read_plane = plane_to_read;
    if (chain_pairs || odd_even_mode) begin
      read_plane = {plane_to_read[1], rd_odd};
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_rdata <= BYTE_ZERO;
      mem_rvalid <= 1'b0;
    end else begin
      mem_rvalid <= (state == ST_RD_WAIT);
      if (state == ST_RD_WAIT) begin
        mem_rdata <= read_path_select ? compare_result : plane_rdata[read_plane];
      end
    end
  end

  // ==========================================================================
  // Write datapath
  logic [7:0] rotated;
  vgpd_planes_t next_wdata;

  assign rotated = rotate_right(mem_wdata, rotate_count);

  for (genvar p = 0; p < 4; p++) begin : g_plane
    vgpd_plane_alu u_alu (
      .mode(write_path_select),
      .func(logic_func),
      .fill_bit(plane_fill_value[p]),
      .fill_en(plane_fill_enable[p]),
      .host_bit(mem_wdata[p]),
      .rotated(rotated),
      .latch(proc_latch[p]),
      .pixel_mask(pixel_write_mask),
      .result(next_wdata[p])
    );
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      plane_we <= NIBBLE_ZERO;
      plane_wdata <= '0;
    end else begin
      plane_we <= wr_take ? (sequencer_plane_mask & pair_planes) : NIBBLE_ZERO;
      if (wr_take) begin
        plane_wdata <= next_wdata;
      end
    end
  end

endmodule : vgpd_graphics_core

`default_nettype wire

// ===== dv/vgpd_graphics_core_properties.sv
// Port-level assertions for the graphics plane core
`default_nettype none

module vgpd_core_props
  import vgpd_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic [HOST_AW-1:0] mem_addr,
  input wire logic mem_wr,
  input wire logic mem_rd,
  input wire logic mem_ready,
  input wire logic mem_hit,
  input wire logic mem_rvalid,
  input wire logic [3:0] sequencer_plane_mask,
  input wire logic plane_rd,
  input wire logic [3:0] plane_we,
  input wire vgpd_video_cfg_t video_cfg
);
  timeunit 1ns;
  timeprecision 1ps;
  // ========
  // Register shadows
  logic [3:0] idx;
  logic [7:0] mask_sh;
  logic [1:0] map_sh;
  logic win_hit;
  logic dwr;
  logic [3:0] pair_m;
  assign dwr = io_wr && io_addr == VGPD_DATA_PORT;
  assign pair_m = (video_cfg.chain_pairs || video_cfg.odd_even_mode) ?
      (mem_addr[0] ? PAIR_ODD : PAIR_EVEN) : 4'hF;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      idx <= 4'h0;
      mask_sh <= 8'h00;
      map_sh <= 2'h0;
    end else begin
      if (io_wr && io_addr == VGPD_INDEX_PORT) idx <= io_wdata[3:0];
      if (dwr && idx == IDX_PIXEL_MASK) mask_sh <= io_wdata;
      if (dwr && idx == IDX_WINDOW_CONTROL) map_sh <= io_wdata[3:2];
    end
  end
  always_comb begin
    case (map_sh)
      2'b00: win_hit = mem_addr[19:17] == 3'b101;
      2'b01: win_hit = mem_addr[19:16] == 4'hA;
      2'b10: win_hit = mem_addr[19:15] == 5'h16;
      default: win_hit = mem_addr[19:15] == 5'h17;
    endcase
  end
  // ========
  // Properties
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_rd_take;
    mem_rd && mem_ready && mem_hit;
  endsequence
  sequence s_rd_answer;
    plane_rd && !mem_ready && plane_we == 4'h0 ##1 mem_rvalid && !mem_ready ##1 mem_ready;
  endsequence
  property p_rd_flow;
    s_rd_take |=> s_rd_answer;
  endproperty
  property p_wr_we;
    mem_wr && !mem_rd && mem_ready && mem_hit |=>
      !plane_rd && plane_we == ($past(sequencer_plane_mask) & $past(pair_m));
  endproperty
  property p_miss;
    (mem_rd || mem_wr) && !mem_hit |=> plane_we == 4'h0 && !plane_rd;
  endproperty
  property p_rvalid;
    mem_rvalid |-> $past(plane_rd) ##1 !mem_rvalid && mem_ready;
  endproperty
  property p_hit;
    mem_hit == win_hit;
  endproperty
  property p_mode_cfg;
    dwr && idx == IDX_MODE_CONTROL |=>
      video_cfg.full_palette_shift == $past(io_wdata[MODE_PAL_BIT]) &&
      video_cfg.legacy_shift_packing == $past(io_wdata[MODE_SR_BIT]) &&
      video_cfg.odd_even_mode == $past(io_wdata[MODE_OE_BIT]);
  endproperty
  property p_misc_cfg;
    dwr && idx == IDX_WINDOW_CONTROL |=> video_cfg.chain_pairs == $past(io_wdata[MISC_COE_BIT])
      && video_cfg.graphics_display_select == $past(io_wdata[MISC_GM_BIT]);
  endproperty
  property p_mask_read;
    io_rd && io_addr == VGPD_DATA_PORT && idx == IDX_PIXEL_MASK |=> io_rdata == mask_sh;
  endproperty
  a_rd_flow: assert property (p_rd_flow) else $error("read handshake wrong");
  a_wr_we: assert property (p_wr_we) else $error("plane enables wrong");
  a_miss: assert property (p_miss) else $error("miss was taken");
  a_rvalid: assert property (p_rvalid) else $error("read valid wrong");
  a_hit: assert property (p_hit) else $error("window decode wrong");
  a_mode_cfg: assert property (p_mode_cfg) else $error("mode levels wrong");
  a_misc_cfg: assert property (p_misc_cfg) else $error("misc levels wrong");
  a_mask_read: assert property (p_mask_read) else $error("mask readback wrong");
endmodule : vgpd_core_props

`default_nettype wire

// ===== dv/vgpd_plane_mem.sv
// Behavioural four-plane display memory
`default_nettype none

module vgpd_plane_mem
  import vgpd_pkg::*;
(
  input wire logic core_clk,
  input wire logic [BUF_AW-1:0] plane_addr,
  input wire logic plane_rd,
  input wire logic [3:0] plane_we,
  input wire vgpd_planes_t plane_wdata,
  output vgpd_planes_t plane_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  vgpd_planes_t mem [0:255];
  vgpd_planes_t junk;
  initial begin
    junk = 32'hA5C3_5A3C;
    for (int a = 0; a < 256; a++) begin
      for (int p = 0; p < 4; p++) begin
        mem[a][p] = 8'(a * 29 + p * 71) ^ 8'h5A;
      end
    end
  end
  // Junk unless read
  always @(posedge core_clk) begin
    junk <= ~junk ^ 32'h1;
    for (int p = 0; p < 4; p++) begin
      if (plane_we[p]) mem[plane_addr[7:0]][p] <= plane_wdata[p];
    end
  end
  assign plane_rdata = plane_rd ? mem[plane_addr[7:0]] : junk;
endmodule : vgpd_plane_mem

`default_nettype wire

// ===== dv/vga_graphics_plane_datapath_bench.sv
// Self-checking bench for the graphics plane core
`default_nettype none

module vga_graphics_plane_datapath_bench
  import vgpd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rst_n, io_wr, io_rd, mem_wr, mem_rd, mem_ready, mem_hit, mem_rvalid, plane_rd;
  logic [15:0] io_addr;
  logic [7:0] io_wdata, io_rdata, mem_wdata, mem_rdata, k, d;
  logic [HOST_AW-1:0] mem_addr;
  logic [3:0] seq_mask, plane_we, we;
  logic [BUF_AW-1:0] plane_addr;
  vgpd_planes_t plane_wdata, plane_rdata, ew;
  vgpd_video_cfg_t video_cfg;
  int num_errors, num_checks, seed;
  logic [7:0] rg [0:8];
  logic [7:0] bm [0:255][0:3];
  logic [7:0] lat [0:3];
  localparam logic [7:0] RMASK [0:8] = '{8'h0F, 8'h0F, 8'h0F, 8'h1F, 8'h03, 8'h7B, 8'h0F,
      8'h0F, 8'hFF};
  localparam logic [19:0] HADDR [0:7] = '{20'hA0000, 20'hAFFFF, 20'hB0000, 20'hB7FFF,
      20'hB8000, 20'hBFFFF, 20'h9FFFF, 20'hC0000};
  localparam logic [19:0] LO [0:3] = '{20'hA0000, 20'hA0000, 20'hB0000, 20'hB8000};
  localparam logic [19:0] HI [0:3] = '{20'hBFFFF, 20'hAFFFF, 20'hB7FFF, 20'hBFFFF};

  always #2.5 core_clk = ~core_clk;

  vgpd_graphics_core i_dut (
    .core_clk(core_clk), .rst_n(rst_n), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .mem_addr(mem_addr), .mem_wr(mem_wr),
    .mem_rd(mem_rd), .mem_wdata(mem_wdata), .mem_ready(mem_ready), .mem_hit(mem_hit),
    .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid), .sequencer_plane_mask(seq_mask),
    .plane_addr(plane_addr), .plane_rd(plane_rd), .plane_we(plane_we),
    .plane_wdata(plane_wdata), .plane_rdata(plane_rdata), .video_cfg(video_cfg)
  );
  vgpd_plane_mem i_mem (
    .core_clk(core_clk), .plane_addr(plane_addr), .plane_rd(plane_rd), .plane_we(plane_we),
    .plane_wdata(plane_wdata), .plane_rdata(plane_rdata)
  );

  // ========
  // Tasks
  task automatic stop_test;
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic wait_sig(input logic rv);
    for (int n = 0; (rv ? mem_rvalid : mem_ready) !== 1'b1; n++) begin
      if (n > 8) begin
        num_errors++;
        stop_test();
      end
      @(negedge core_clk);
    end
  endtask : wait_sig
  task automatic io_w(input logic [15:0] a, input logic [7:0] v);
    @(negedge core_clk);
    io_addr = a;
    io_wdata = v;
    io_wr = 1'b1;
    @(negedge core_clk);
    io_wr = 1'b0;
  endtask : io_w
  task automatic reg_r(input logic [3:0] i, input logic [7:0] e);
    io_w(VGPD_INDEX_PORT, {4'h0, i});
    @(negedge core_clk);
    io_addr = VGPD_DATA_PORT;
    io_rd = 1'b1;
    @(negedge core_clk);
    io_rd = 1'b0;
    chk(io_rdata, e);
  endtask : reg_r
  task automatic mem_op(input logic wr, input logic [19:0] a, input logic [7:0] v);
    @(negedge core_clk);
    wait_sig(1'b0);
    mem_addr = a;
    mem_wdata = v;
    mem_wr = wr;
    mem_rd = !wr;
    @(negedge core_clk);
    mem_wr = 1'b0;
    mem_rd = 1'b0;
    if (!wr) wait_sig(1'b1);
  endtask : mem_op
  function automatic logic [7:0] wr_exp(input int p, input logic [7:0] v);
    logic [15:0] dd;
    logic [7:0] s, m, l;
    dd = {v, v} >> rg[3][2:0];
    l = lat[p];
    m = rg[8];
    case (rg[5][1:0])
      2'b00: s = rg[1][p] ? {8{rg[0][p]}} : dd[7:0];
      2'b01: s = l;
      2'b10: s = {8{v[p]}};
      default: s = {8{rg[0][p]}};
    endcase
    if (rg[5][1:0] == 2'b01) m = 8'h00;
    if (rg[5][1:0] == 2'b11) m = dd[7:0] & rg[8];
    case (rg[3][4:3])
      2'b01: s = s & l;
      2'b10: s = s | l;
      2'b11: s = s ^ l;
      default: s = s;
    endcase
    return (s & m) | (l & ~m);
  endfunction : wr_exp
  function automatic logic [7:0] rd_exp(input logic [7:0] a);
    logic [7:0] r;
    if (!rg[5][3]) return bm[a][rg[5][4] ? {rg[4][1], a[0]} : rg[4][1:0]];
    r = 8'hFF;
    for (int b = 0; b < 8; b++) begin
      for (int p = 0; p < 4; p++) begin
        if (rg[7][p] && bm[a][p][b] != rg[2][p]) r[b] = 1'b0;
      end
    end
    return r;
  endfunction : rd_exp

  // ========
  // Main sequence
  initial begin
    seed = 32'h7EE7;
    num_errors = 0;
    num_checks = 0;
    {rst_n, io_wr, io_rd, mem_wr, mem_rd} = 5'h00;
    io_addr = 16'h0000;
    io_wdata = 8'h00;
    mem_addr = 20'h00000;
    mem_wdata = 8'h00;
    seq_mask = 4'h0;
    for (int a = 0; a < 256; a++) begin
      for (int p = 0; p < 4; p++) begin
        bm[a][p] = 8'(a * 29 + p * 71) ^ 8'h5A;
      end
    end
    repeat (16) @(negedge core_clk);
    rst_n = 1'b1;
    for (int it = 0; it < 64; it++) begin
      for (int i = 0; i < 9; i++) begin
        rg[i] = 8'($random(seed)) & RMASK[i];
      end
      rg[3][4:3] = it[3:2];
      rg[5] = {1'b0, rg[5][6:5], it[5], it[4], 1'b0, it[1:0]};
      rg[6] = {7'h00, rg[6][0]};
      for (int i = 0; i < 9; i++) begin
        io_w(VGPD_INDEX_PORT, 8'(i));
        io_w(VGPD_DATA_PORT, rg[i]);
      end
      for (int i = 0; i < 10; i++) begin
        reg_r(i[3:0], (i < 9) ? rg[i % 9] : 8'h00);
      end
      chk(video_cfg, {rg[5][6:4], rg[6][1:0]});
      seq_mask = 4'($random(seed));
      k = 8'($random(seed));
      mem_op(1'b0, WIN_BASE_A0 + k, 8'h00);
      chk(mem_rdata, rd_exp(k));
      lat = bm[k];
      d = 8'($random(seed));
      we = seq_mask & (rg[5][4] ? (k[0] ? 4'hA : 4'h5) : 4'hF);
      mem_op(1'b1, WIN_BASE_A0 + k, d);
      for (int p = 0; p < 4; p++) begin
        ew[p] = wr_exp(p, d);
        if (we[p]) bm[k][p] = ew[p];
      end
      chk(plane_wdata, ew);
      chk({plane_we, 3'h0, plane_addr}, {we, 12'h000, k});
    end
    for (int m = 0; m < 4; m++) begin
      io_w(VGPD_INDEX_PORT, 8'(IDX_WINDOW_CONTROL));
      io_w(VGPD_DATA_PORT, 8'(m << 2));
      for (int j = 0; j < 8; j++) begin
        @(negedge core_clk);
        mem_addr = HADDR[j];
        #1 chk(mem_hit, HADDR[j] >= LO[m] && HADDR[j] <= HI[m]);
      end
    end
    mem_op(1'b1, WIN_BASE_A0, 8'h00);
    chk(plane_we, 4'h0);
    io_w(VGPD_DATA_PORT, 8'h02);
    seq_mask = 4'hF;
    mem_op(1'b1, 20'hA4001, 8'h00);
    chk({plane_we, plane_addr[0]}, {4'hA, 1'b1});
    mem_op(1'b1, 20'hA0000, 8'h00);
    chk({plane_we, plane_addr[0]}, {4'h5, 1'b0});
    stop_test();
  end
endmodule : vga_graphics_plane_datapath_bench

bind vgpd_graphics_core vgpd_core_props i_props (
  .core_clk(core_clk), .rst_n(rst_n), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
  .io_wdata(io_wdata), .io_rdata(io_rdata), .mem_addr(mem_addr), .mem_wr(mem_wr),
  .mem_rd(mem_rd), .mem_ready(mem_ready), .mem_hit(mem_hit), .mem_rvalid(mem_rvalid),
  .sequencer_plane_mask(sequencer_plane_mask), .plane_rd(plane_rd), .plane_we(plane_we),
  .video_cfg(video_cfg)
);

`default_nettype wire
